//--- logic/adcctl_pkg.sv
// Package with register map, field positions and reset values of the converter control block
package adcctl_pkg;
    localparam logic [11:0] ADCCTL_CONTROL0_ADDR = 12'hF70;  // adc_control0 byte address
    localparam logic [7:0]  ADCCTL_CONTROL0_RST  = 8'h00;
    localparam int          ADCCTL_START_BIT     = 7;
    localparam int          ADCCTL_REF_BIT       = 5;
    localparam int          ADCCTL_EN_BIT        = 4;
    localparam int          ADCCTL_SEL_MSB       = 2;
    localparam logic [7:0]  ADCCTL_WR_MASK       = 8'h37;   // Stored bits; reserved 6 and 3 read 0
    localparam logic [1:0]  ADCCTL_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  ADCCTL_RESP_SLVERR   = 2'h2;
    localparam logic [7:0]  ADCCTL_CHAN_ONEHOT0  = 8'h01;
endpackage

//--- logic/adcctl_top.sv
// Converter control register with AXI4-Lite slave and converter core handshake
`timescale 1ns/1ns
// Overview of operation
// [R1] One 8-bit control register sits at F70h and every bit clears to zero on reset.
// [R2] Writing a one to bit 7 starts a new conversion.
// [R3] Writing a zero to bit 7 leaves any conversion in progress untouched.
// [R4] Bit 7 reads one while a conversion runs and zero when the converter is idle.
// [R5] Bit 5 turns on the internal reference; at zero an external reference is used.
// [R6] Bit 4 enables the converter; at zero it stays disabled to save power.
// [R7] Software always writes zero to reserved bits 6 and 3.
// [R8] Bits 2 to 0 route analog input n to the converter, code 000 to input 0, 111 to input 7.
// [R9] Hardware clears the busy bit when the running conversion completes.
module adcctl_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // AXI4-Lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Converter core side
    output logic             conv_start,
    input  wire logic        conv_done,
    output logic             internal_ref_enable,
    output logic             converter_enable,
    output logic [7:0]       input_channel_select
);
    import adcctl_pkg::*;

    logic [7:0]  ctrl_q;          // Stored bits 5,4,2:0
    logic        busy_q;
    logic        aw_got_q, w_got_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    // Address match used by both write and read paths
    function automatic logic addr_hit(input logic [11:0] a);
        return a[11:2] == ADCCTL_CONTROL0_ADDR[11:2];
    endfunction

    // Write path decoding: fire once both halves are held and no response is pending
    wire       wr_fire   = aw_got_q && w_got_q && !s_axi_bvalid;
    wire       wr_hit    = wr_fire && addr_hit(awaddr_q) && wstrb_q[0];
    wire       start_req = wr_hit && wdata_q[ADCCTL_START_BIT]; // [R2]
    // A done pulse that meets a new start in the same cycle is overridden: start has priority
    wire       busy_d    = start_req ? 1'b1 : (conv_done ? 1'b0 : busy_q); // [R3] [R9]
    wire [7:0] status_rd = {busy_q, 1'b0, ctrl_q[5:0] & ADCCTL_WR_MASK[5:0]}; // [R4]
    wire [7:0] chan_dec  = ADCCTL_CHAN_ONEHOT0 << ctrl_q[ADCCTL_SEL_MSB:0]; // [R8]

    // Capture write address and data independently, in either order
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // Ready flags registered so each channel takes one item per transaction
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Write response: unmapped addresses answer SLVERR
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ADCCTL_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_hit(awaddr_q) ? ADCCTL_RESP_OKAY : ADCCTL_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register; reserved bits are never stored, so stray ones cannot leak out
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= ADCCTL_CONTROL0_RST; // [R1]
            busy_q <= 1'b0; // [R1]
        end else begin
            busy_q <= busy_d;
            if (wr_hit) begin
                ctrl_q <= wdata_q[7:0] & ADCCTL_WR_MASK; // [R5] [R6] [R7]
            end
        end
    end

    // Converter side outputs, all registered
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            conv_start           <= 1'b0;
            internal_ref_enable  <= 1'b0;
            converter_enable     <= 1'b0;
            input_channel_select <= ADCCTL_CHAN_ONEHOT0;
        end else begin
            conv_start           <= start_req; // [R2]
            internal_ref_enable  <= ctrl_q[ADCCTL_REF_BIT]; // [R5]
            converter_enable     <= ctrl_q[ADCCTL_EN_BIT]; // [R6]
            input_channel_select <= chan_dec; // [R8]
        end
    end

    // Read path: one read at a time, answer one cycle after the address is taken
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ADCCTL_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= addr_hit(s_axi_araddr) ? {24'h00_0000, status_rd} : 32'h0;
                s_axi_rresp  <= addr_hit(s_axi_araddr) ? ADCCTL_RESP_OKAY : ADCCTL_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks sit beside the logic they guard; only the reset check watches reset itself

    // Reset leaves every stored bit and the busy flag clear
    reset_clear_a: assert property (@(posedge sys_clk) // [R1]
        $rose(nrst) |-> ctrl_q == ADCCTL_CONTROL0_RST && !busy_q)
        else $error("register not clear after reset");
    // An unmapped write is answered with an error response
    unmapped_err_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
        wr_fire && !addr_hit(awaddr_q) |=> s_axi_bvalid && s_axi_bresp == ADCCTL_RESP_SLVERR)
        else $error("unmapped write not answered with error");
    // An unmapped write must not leak into the control register
    unmapped_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
        wr_fire && !addr_hit(awaddr_q) |=> $stable(ctrl_q))
        else $error("unmapped write changed the register");
    // A start write raises busy and the start pulse on the next edge
    start_busy_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
        start_req |=> busy_q && conv_start)
        else $error("start write did not set busy");
    // Writes are spaced by the bus answer, so a start pulse never lasts two cycles
    start_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
        conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    // Busy only ever rises through a start write
    busy_source_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
        !busy_q && !start_req |=> !busy_q)
        else $error("busy rose without a start write");
    // A zero in the start bit neither aborts nor restarts a conversion
    zero_keeps_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
        wr_hit && !wdata_q[ADCCTL_START_BIT] && !conv_done |=> busy_q == $past(busy_q))
        else $error("zero start write altered busy");
    // The start bit reads back the busy state at the moment the address was taken
    busy_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
        s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr)
        |=> s_axi_rdata[ADCCTL_START_BIT] == $past(busy_q))
        else $error("busy bit read mismatch");
    // Reference enable reaches its pin two edges after the write fires
    ref_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R5]
        wr_hit |=> ##1 internal_ref_enable == $past(wdata_q[ADCCTL_REF_BIT], 2))
        else $error("reference enable mismatch");
    // Converter enable reaches its pin two edges after the write fires
    enable_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R6]
        wr_hit |=> ##1 converter_enable == $past(wdata_q[ADCCTL_EN_BIT], 2))
        else $error("converter enable mismatch");
    // Reserved bits are never stored, so any answer shows them as zero
    reserved_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
        s_axi_rvalid |-> !s_axi_rdata[6] && !s_axi_rdata[3])
        else $error("reserved bit read as one");
    // Channel select follows the stored field one edge later
    chan_route_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
        input_channel_select == (8'h01 << $past(ctrl_q[ADCCTL_SEL_MSB:0])))
        else $error("channel select mismatch");
    // Exactly one analog input is routed at any time
    chan_onehot_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
        $onehot(input_channel_select))
        else $error("channel select not one-hot");
    // A done pulse without a new start ends the busy state
    done_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R9]
        conv_done && !start_req |=> !busy_q)
        else $error("busy not cleared at done");

    // Main scenarios: a start, a finished conversion, an error answer, a busy read
    write_cov: cover property (@(posedge sys_clk) disable iff (!nrst) start_req);
    done_cov: cover property (@(posedge sys_clk) disable iff (!nrst) busy_q ##[1:20] !busy_q);
    err_cov: cover property (@(posedge sys_clk) disable iff (!nrst)
        s_axi_bvalid && s_axi_bresp == 2'h2);
    busy_read_cov: cover property (@(posedge sys_clk) disable iff (!nrst)
        s_axi_rvalid && s_axi_rdata[ADCCTL_START_BIT]);
endmodule

//--- testbench/adcctl_conv_model.sv
// Converter core model: one done pulse CONV_CYCLES + 1 edges after the latest start pulse rises
`timescale 1ns/1ns
module adcctl_conv_model #(parameter int CONV_CYCLES = 30) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Core handshake
    input  wire logic conv_start,
    output logic      conv_done
);
    int cnt_q;
    // A start that lands mid-count restarts it, as a real core would
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q     <= 0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt_q == 1);
            cnt_q     <= conv_start ? CONV_CYCLES : (cnt_q > 0 ? cnt_q - 1 : 0);
        end
    end
endmodule

//--- testbench/converter_control_register_tb.sv
// Self-checking bench for the converter control register
`timescale 1ns/1ns
module converter_control_register_tb;
    import adcctl_pkg::*;
    logic        sys_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid, cst, cdone, ref_en, c_en;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  sel, v;
    logic [15:0] lfsr = 16'h8341;
    int          bad_count = 0, checks = 0, m_busy = 0, m_reg = 0, starts = 0;
    int          m_start_q[$];  // One entry per start write the model expects to see pulsed
    adcctl_top dut (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_start(cst),
        .conv_done(cdone), .internal_ref_enable(ref_en), .converter_enable(c_en),
        .input_channel_select(sel));
    adcctl_conv_model core (.sys_clk(sys_clk), .nrst(nrst), .conv_start(cst), .conv_done(cdone));
    always #5 sys_clk = ~sys_clk;
    // Reference model: busy falls with the core's done pulse, start pulses are counted
    always @(posedge sys_clk) begin
        if (cdone) m_busy <= 0;
        if (cst) starts <= starts + 1;
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Register value the model expects a mapped read to return
    function automatic logic [31:0] exp_rd();
        return m_reg | (m_busy << 7);
    endfunction
    task conclude;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Read data of the last read
    task chk_reg(input string nm, input logic [31:0] e);
        chk(nm, e, got);
    endtask
    // Response code of the last write or read
    task chk_resp(input string nm, input logic [1:0] e);
        chk(nm, e, resp);
    endtask
    // Converter side pins against the model's stored fields
    task chk_pins;
        chk("ref out", m_reg[5], ref_en);
        chk("enable out", m_reg[4], c_en);
        chk("select out", 8'h01 << m_reg[2:0], sel);
    endtask
    // Event counts; plain integers cannot hide unknowns
    task chk_count(input string nm, input int e, input int g);
        chk(nm, e, g);
    endtask
    task guard(inout int n);
        n++;
        if (n > 200) begin
            bad_count++;
            conclude;
        end
    endtask
    // Address and data offered together, each dropped once taken; the model follows the write
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
        int n = 0;
        @(posedge sys_clk);
        lfsr = nxt(lfsr);
        awaddr  <= a;
        awvalid <= 1;
        wdata   <= {lfsr, 8'h00, d};
        wstrb   <= s;
        wvalid  <= 1;
        bready  <= 1;
        do begin
            @(posedge sys_clk);
            guard(n);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        resp = bresp;
        bready <= 0;
        if (a == ADCCTL_CONTROL0_ADDR && s[0]) begin
            m_reg = d & ADCCTL_WR_MASK;
            if (d[ADCCTL_START_BIT]) begin
                m_busy = 1;
                m_start_q.push_back(m_start_q.size());
            end
        end
    endtask
    task automatic rd(input logic [11:0] a);
        int n = 0;
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1;
        rready  <= 1;
        do begin
            @(posedge sys_clk);
            guard(n);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        got = rdata;
        resp = rresp;
        rready <= 0;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1;
        repeat (2) @(posedge sys_clk);
        rd(ADCCTL_CONTROL0_ADDR);
        chk_reg("reset value", ADCCTL_CONTROL0_RST);
        chk_pins;
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            lfsr = nxt(lfsr);
            v = {2'b00, lfsr[1:0], 1'b0, c[2:0]};
            wr(ADCCTL_CONTROL0_ADDR, v);
            chk_resp("write resp", ADCCTL_RESP_OKAY);
            rd(ADCCTL_CONTROL0_ADDR);
            chk_reg("readback", exp_rd());
            repeat (2) @(posedge sys_clk);
            chk_pins;
        end
        $display("test fields done");
        wr(ADCCTL_CONTROL0_ADDR, 8'h93);
        rd(ADCCTL_CONTROL0_ADDR);
        chk_reg("busy read", exp_rd());
        wr(ADCCTL_CONTROL0_ADDR, 8'h15);
        rd(ADCCTL_CONTROL0_ADDR);
        chk_reg("busy kept", exp_rd());
        chk_pins;
        repeat (40) @(posedge sys_clk);
        rd(ADCCTL_CONTROL0_ADDR);
        chk_reg("busy cleared", exp_rd());
        chk_count("done seen", 0, m_busy);
        $display("test conversion done");
        wr(ADCCTL_CONTROL0_ADDR, 8'h20, 4'h0);
        chk_resp("masked resp", ADCCTL_RESP_OKAY);
        rd(ADCCTL_CONTROL0_ADDR);
        chk_reg("masked write", exp_rd());
        rd(12'h0F4);
        chk_reg("unmapped data", 32'h0);
        chk_resp("unmapped rresp", ADCCTL_RESP_SLVERR);
        wr(12'h0F4, 8'h37);
        chk_resp("unmapped bresp", ADCCTL_RESP_SLVERR);
        rd(ADCCTL_CONTROL0_ADDR);
        chk_reg("untouched", exp_rd());
        $display("test unmapped done");
        wr(ADCCTL_CONTROL0_ADDR, 8'hB7);
        @(posedge sys_clk);
        nrst <= 0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1;
        m_reg = 0;
        m_busy = 0;
        repeat (2) @(posedge sys_clk);
        rd(ADCCTL_CONTROL0_ADDR);
        chk_reg("reset mid-run", exp_rd());
        chk_pins;
        chk_count("start pulses", m_start_q.size(), starts);
        $display("test reset again done");
        conclude;
    end
endmodule
